// ===== hdl/pad_cfg_regs.svh
// register offsets, field positions, reset values and bus constants of the pad register bank
`ifndef PAD_CFG_REGS_SVH
`define PAD_CFG_REGS_SVH

// ==========================================================================
// bus geometry
// ==========================================================================
`define PAD_ADDR_W          12
`define PAD_DATA_W          32

// ==========================================================================
// register byte offsets
// ==========================================================================
`define OFS_P3A_HYST        12'h0e0
`define OFS_P3B_HYST        12'h0e4
`define OFS_P3C_HYST        12'h0e8
`define OFS_P3D_HYST        12'h0ec
`define OFS_P1A_DRIVE       12'h0f0
`define OFS_P1B_DRIVE       12'h0f4
`define OFS_P1C_DRIVE       12'h0f8
`define OFS_P1D_DRIVE       12'h0fc
`define OFS_P2A_DRIVE       12'h100

// ==========================================================================
// field positions
// ==========================================================================
`define MASK_LSB            16
`define MASK_MSB            31
`define HYST_MSB            7
`define RESV_HYST_LSB       8

// ==========================================================================
// reset values
// ==========================================================================
`define HYST_RST            8'h00
`define P1A_DRIVE_RST       16'haaaa
`define P1B_DRIVE_RST       16'haaaa
`define P1C_DRIVE_RST       16'haa55
`define P1D_DRIVE_RST       16'haaaa
`define P2A_DRIVE_RST       16'h5555

`endif

// ===== hdl/pad_cfg_pkg.sv
// types shared by the pad register bank and its bench
package pad_cfg_pkg;

    // ======================================================================
    // pad control bundle: what the bank drives to the pad ring
    // ======================================================================
    // drive-strength code per pin
    typedef enum logic [1:0] {
        DRIVE_2MA  = 2'b00,
        DRIVE_4MA  = 2'b01,
        DRIVE_8MA  = 2'b10,
        DRIVE_12MA = 2'b11
    } drive_sel_t;

    // hysteresis_en[g][n]: port 3 group g (a..d), pin n
    // drive_sel[g][n]: g 0..3 = port 1 groups a..d, g 4 = port 2 group a
    typedef struct packed {
        logic [3:0][7:0]      hysteresis_en;
        logic [4:0][7:0][1:0] drive_sel;
    } pad_ctrl_t;

    // ======================================================================
    // bus side types
    // ======================================================================
    typedef enum logic [1:0] {
        RESP_OKAY   = 2'b00,
        RESP_SLVERR = 2'b10,
        RESP_DECERR = 2'b11
    } axi_resp_t;

    // a write collected from the address and data channels
    typedef struct packed {
        logic [11:0] addr;
        logic [31:0] data;
        logic [3:0]  strb;
    } axi_wr_t;

    // read channel phase
    typedef enum logic [0:0] {
        RD_IDLE = 1'b0,
        RD_RESP = 1'b1
    } rd_state_t;

endpackage

// ===== hdl/pad_hysteresis_drive_regs.sv
// pad hysteresis and drive-strength register bank with an AXI4-Lite slave
//
// Function
// - lower bit n written only if bit 16+n set
// - clear mask bit leaves stored bit unchanged
// - sixteen mask pairs, bit 31 gates bit 15
// - per-pin hysteresis enable bits 7:0, reset 0
// - hysteresis bits 15:8 reserved, read zero
// - two-bit drive code steers the pin's pad
// - drive pin n sits at bits 2n+1:2n
// - drive resets 0x2; group C pins 3:0 and port 2 group A 0x1
`timescale 1ns/1ps
`include "pad_cfg_regs.svh"

module pad_hysteresis_drive_regs
    import pad_cfg_pkg::*;
(
    input  wire  logic                     mclk,
    input  wire  logic                     reset,
    // write address channel
    input  wire  logic                     awvalid,
    output logic                           awready,
    input  wire  logic [`PAD_ADDR_W-1:0]   awaddr,
    input  wire  logic [2:0]               awprot,
    // write data channel
    input  wire  logic                     wvalid,
    output logic                           wready,
    input  wire  logic [`PAD_DATA_W-1:0]   wdata,
    input  wire  logic [3:0]               wstrb,
    // write response channel
    output logic                           bvalid,
    input  wire  logic                     bready,
    output logic [1:0]                     bresp,
    // read address channel
    input  wire  logic                     arvalid,
    output logic                           arready,
    input  wire  logic [`PAD_ADDR_W-1:0]   araddr,
    input  wire  logic [2:0]               arprot,
    // read data channel
    output logic                           rvalid,
    input  wire  logic                     rready,
    output logic [`PAD_DATA_W-1:0]         rdata,
    output logic [1:0]                     rresp,
    // pad ring controls
    output pad_ctrl_t                      pad_ctrl
);

    // ======================================================================
    // declarations
    // ======================================================================
    // selects 0..3 are the hysteresis groups, 4..8 the drive groups
    localparam logic [3:0] SEL_NONE = 4'hf;     // decode miss

    pad_ctrl_t   pad_q;                         // the stored settings
    axi_wr_t     wr_q;                          // collected write
    logic        aw_full_q;                     // address held
    logic        w_full_q;                      // data held
    logic        awready_q;
    logic        wready_q;
    logic        bvalid_q;
    logic [1:0]  bresp_q;
    rd_state_t   rd_state_q;
    logic        arready_q;
    logic [31:0] rdata_q;
    logic [1:0]  rresp_q;

    logic        aw_take;                       // address handshake this edge
    logic        w_take;                        // data handshake this edge
    logic        commit;                        // both halves held, apply now
    logic        aw_full_d;
    logic        w_full_d;
    logic        bvalid_d;
    logic [3:0]  wr_sel;                        // decoded write target
    logic [3:0]  rd_sel;                        // decoded read target
    logic [15:0] wr_mask;                       // effective per-bit enables
    logic [15:0] wr_val;                        // lower half of written word
    logic [3:0][15:0] hyst_wide;                // masked result, hysteresis groups
    logic [4:0][15:0] drive_next;               // masked result, drive groups

    // prot is accepted but has no effect: every register is open to all
    logic [2:0]  prot_unused;
    assign prot_unused = awprot | arprot;

    // ======================================================================
    // helpers
    // ======================================================================
    // map a byte address to a register select; the two low bits are ignored
    // limitation: any byte address inside a word aliases to that word
    function automatic logic [3:0] decode(input logic [`PAD_ADDR_W-1:0] a);
        logic [`PAD_ADDR_W-1:0] w;
        w = {a[`PAD_ADDR_W-1:2], 2'b00};
        case (w)
            `OFS_P3A_HYST:  decode = 4'h0;
            `OFS_P3B_HYST:  decode = 4'h1;
            `OFS_P3C_HYST:  decode = 4'h2;
            `OFS_P3D_HYST:  decode = 4'h3;
            `OFS_P1A_DRIVE: decode = 4'h4;
            `OFS_P1B_DRIVE: decode = 4'h5;
            `OFS_P1C_DRIVE: decode = 4'h6;
            `OFS_P1D_DRIVE: decode = 4'h7;
            `OFS_P2A_DRIVE: decode = 4'h8;
            default:        decode = SEL_NONE;
        endcase
    endfunction

    // bitwise masked update: only enabled bits take the new value
    function automatic logic [15:0] masked(input logic [15:0] old,
                                           input logic [15:0] val,
                                           input logic [15:0] en);
        masked = (old & ~en) | (val & en);
    endfunction

    // ======================================================================
    // write path: address and data in either order, then one response
    // ======================================================================
    // timing: the later of the two handshakes lands at edge k, the register
    // moves at edge k+1 together with bvalid rising, and bvalid stands until
    // the edge that sees bready; both readies stay low from their own
    // handshake until after that edge, so only one write is ever in flight
    assign aw_take = awvalid & awready_q;
    assign w_take  = wvalid & wready_q;
    // one cycle after both halves are held the register is updated
    assign commit  = aw_full_q & w_full_q & ~bvalid_q;

    assign aw_full_d = commit ? 1'b0 : (aw_full_q | aw_take);
    assign w_full_d  = commit ? 1'b0 : (w_full_q | w_take);
    assign bvalid_d  = commit ? 1'b1 : (bvalid_q & ~bready);

    assign wr_sel = decode(wr_q.addr);
    assign wr_val = wr_q.data[15:0];
    // a mask bit counts only when its byte lane and its data lane are strobed,
    // so a partial-strobe write can never move a bit software did not send
    assign wr_mask[7:0]  = wr_q.data[`MASK_LSB+7:`MASK_LSB]
                         & {8{wr_q.strb[2] & wr_q.strb[0]}};
    assign wr_mask[15:8] = wr_q.data[`MASK_MSB:`MASK_LSB+8]
                         & {8{wr_q.strb[3] & wr_q.strb[1]}};

    // channel handshake flags
    // reset leaves both readies high so the first write is taken at once
    always_ff @(posedge mclk) begin
        if (reset) begin
            aw_full_q <= 1'b0;
            w_full_q  <= 1'b0;
            awready_q <= 1'b1;
            wready_q  <= 1'b1;
            bvalid_q  <= 1'b0;
        end else begin
            aw_full_q <= aw_full_d;
            w_full_q  <= w_full_d;
            // ready drops once a half is held and stays low through the answer
            awready_q <= ~aw_full_d & ~bvalid_d;
            wready_q  <= ~w_full_d & ~bvalid_d;
            bvalid_q  <= bvalid_d;
        end
    end

    // payload capture, each half on its own handshake
    // the halves may arrive in either order; each is kept until commit
    always_ff @(posedge mclk) begin
        if (reset) begin
            wr_q <= '0;
        end else begin
            if (aw_take) begin
                wr_q.addr <= awaddr;
            end
            if (w_take) begin
                wr_q.data <= wdata;
                wr_q.strb <= wstrb;
            end
        end
    end

    // write response code: reserved bits never raise an error
    always_ff @(posedge mclk) begin
        if (reset) begin
            bresp_q <= RESP_OKAY;
        end else if (commit) begin
            bresp_q <= (wr_sel == SEL_NONE) ? RESP_DECERR : RESP_OKAY;
        end
    end

    // ======================================================================
    // masked next values
    // ======================================================================
    // every group's candidate is formed each cycle and the commit edge picks
    // one by select; the reserved upper byte of a hysteresis group enters as
    // zero and is dropped on store
    always_comb begin
        for (int g = 0; g < 4; g++) begin
            hyst_wide[g] = masked({8'h00, pad_q.hysteresis_en[g]},
                                  wr_val, wr_mask);
        end
        for (int g = 0; g < 5; g++) begin
            drive_next[g] = masked(pad_q.drive_sel[g],
                                   wr_val, wr_mask);
        end
    end

    // ======================================================================
    // register storage
    // ======================================================================
    // a write is applied only on its commit edge and only to the decoded
    // group; everything else keeps its value, which keeps the pads quiet
    // between writes
    always_ff @(posedge mclk) begin
        if (reset) begin
            for (int g = 0; g < 4; g++) begin
                pad_q.hysteresis_en[g] <= `HYST_RST;
            end
            pad_q.drive_sel[0] <= `P1A_DRIVE_RST;
            pad_q.drive_sel[1] <= `P1B_DRIVE_RST;
            // port1_c_pin3_drive_sel and below come up at 4mA
            pad_q.drive_sel[2] <= `P1C_DRIVE_RST;
            pad_q.drive_sel[3] <= `P1D_DRIVE_RST;
            pad_q.drive_sel[4] <= `P2A_DRIVE_RST;
        end else if (commit) begin
            for (int g = 0; g < 4; g++) begin
                if (wr_sel == 4'(g)) begin
                    // upper byte is reserved: its data and mask are dropped
                    pad_q.hysteresis_en[g] <= hyst_wide[g][`HYST_MSB:0];
                end
            end
            for (int g = 0; g < 5; g++) begin
                if (wr_sel == 4'(g + 4)) begin
                    // pin n occupies bits 2n+1:2n of the packed group
                    pad_q.drive_sel[g] <= drive_next[g];
                end
            end
        end
    end

    // ======================================================================
    // read path: one answer per request, one cycle after the handshake
    // ======================================================================
    // timing: the word is captured at the address handshake, so rvalid and
    // rdata appear one edge later and stand until rready; a write that
    // commits on the same edge is seen by the next read, not by this one
    assign rd_sel = decode(araddr);

    always_ff @(posedge mclk) begin
        if (reset) begin
            rd_state_q <= RD_IDLE;
            arready_q  <= 1'b1;
        end else begin
            case (rd_state_q)
                RD_IDLE: begin
                    if (arvalid) begin
                        rd_state_q <= RD_RESP;
                        arready_q  <= 1'b0;
                    end
                end
                RD_RESP: begin
                    // hold the answer until the master takes it
                    if (rready) begin
                        rd_state_q <= RD_IDLE;
                        arready_q  <= 1'b1;
                    end
                end
                default: begin
                    rd_state_q <= RD_IDLE;
                    arready_q  <= 1'b1;
                end
            endcase
        end
    end

    // read data: the mask half always reads zero, as do reserved bits
    always_ff @(posedge mclk) begin
        if (reset) begin
            rdata_q <= 32'h0000_0000;
            rresp_q <= RESP_OKAY;
        end else if (rd_state_q == RD_IDLE && arvalid) begin
            rresp_q <= RESP_OKAY;
            if (rd_sel < 4'h4) begin
                rdata_q <= {24'h00_0000,
                            pad_q.hysteresis_en[rd_sel[1:0]]};
            end else if (rd_sel <= 4'h8) begin
                rdata_q <= {16'h0000,
                            pad_q.drive_sel[3'(rd_sel - 4'h4)]};
            end else begin
                // unmapped word: zero data and a decode error
                rdata_q <= 32'h0000_0000;
                rresp_q <= RESP_DECERR;
            end
        end
    end

    // ======================================================================
    // outputs, all straight from flip-flops
    // ======================================================================
    assign awready  = awready_q;
    assign wready   = wready_q;
    assign bvalid   = bvalid_q;
    assign bresp    = bresp_q;
    assign arready  = arready_q;
    // rvalid is the read state flip-flop itself: its one-bit encoding makes
    // the comparison a plain wire
    assign rvalid   = (rd_state_q == RD_RESP);
    assign rdata    = rdata_q;
    assign rresp    = rresp_q;
    // each code selects 2, 4, 8 or 12 mA at its pin's pad
    assign pad_ctrl = pad_q;

endmodule // pad_hysteresis_drive_regs

// ===== bench/pad_regs_monitor.sv
// port-level assertions for the pad hysteresis and drive register bank
`timescale 1ns/1ps
`include "pad_cfg_regs.svh"

module pad_regs_monitor
    import pad_cfg_pkg::*;
(
    input wire logic        mclk,
    input wire logic        reset,
    input wire logic        awvalid,
    input wire logic        awready,
    input wire logic        wvalid,
    input wire logic        wready,
    input wire logic        bvalid,
    input wire logic        bready,
    input wire logic [1:0]  bresp,
    input wire logic        arvalid,
    input wire logic        arready,
    input wire logic [11:0] araddr,
    input wire logic        rvalid,
    input wire logic        rready,
    input wire logic [31:0] rdata,
    input wire logic [1:0]  rresp,
    input wire pad_ctrl_t   pad_ctrl
);
    // ======================================================================
    // one domain, so one default clock and reset
    // ======================================================================
    default clocking cb @(posedge mclk); endclocking
    default disable iff (reset);

    // read request accepted
    sequence s_rd_take;
        arvalid && arready;
    endsequence
    // commit edge first, response one edge later
    sequence s_commit_gap;
        !bvalid ##1 bvalid;
    endsequence

    // ======================================================================
    // read channel
    // ======================================================================
    a_rd_latency: assert property (s_rd_take |=> rvalid && !arready)
        else $error("read answer not one edge after request");
    a_rd_hold: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
        else $error("read answer dropped before rready");
    a_upper_zero: assert property (rvalid |-> rdata[31:16] == 16'h0000)
        else $error("mask half did not read zero");
    // reads return the settings as they stood at the request edge
    a_hyst_readback: assert property (s_rd_take ##0 (araddr == `OFS_P3A_HYST)
        |=> rdata == {24'h00_0000, $past(pad_ctrl.hysteresis_en[0])})
        else $error("hysteresis read differs from pad enables");
    a_drive_readback: assert property (s_rd_take ##0 (araddr == `OFS_P1A_DRIVE)
        |=> rdata == {16'h0000, $past(pad_ctrl.drive_sel[0])})
        else $error("drive read differs from pad codes");
    a_unmapped_read: assert property (s_rd_take ##0 (araddr == 12'h104)
        |=> rresp == 2'h3 && rdata == 32'h0000_0000)
        else $error("unmapped read not refused");

    // ======================================================================
    // write channel and pad outputs
    // ======================================================================
    a_wr_commit: assert property (awvalid && awready && wvalid && wready |=> s_commit_gap)
        else $error("write response not two edges after request");
    a_b_hold: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
        else $error("write response dropped before bready");
    a_wr_blocked: assert property (bvalid |-> !awready && !wready)
        else $error("new write offered while response pending");
    a_pad_quiet: assert property ($changed(pad_ctrl) |-> $rose(bvalid))
        else $error("pad controls moved without a write");
endmodule // pad_regs_monitor

bind pad_hysteresis_drive_regs pad_regs_monitor mon (
    .mclk(mclk), .reset(reset), .awvalid(awvalid), .awready(awready),
    .wvalid(wvalid), .wready(wready), .bvalid(bvalid), .bready(bready), .bresp(bresp),
    .arvalid(arvalid), .arready(arready), .araddr(araddr), .rvalid(rvalid),
    .rready(rready), .rdata(rdata), .rresp(rresp), .pad_ctrl(pad_ctrl));

// ===== bench/tb_pad_hysteresis_drive_regs.sv
// self-checking bench for the pad hysteresis and drive register bank
`timescale 1ns/1ps
`include "pad_cfg_regs.svh"

module tb_pad_hysteresis_drive_regs
    import pad_cfg_pkg::*;
;
    // ======================================================================
    // bench signals
    // ======================================================================
    logic        mclk, reset;
    logic        awvalid, awready, wvalid, wready, bvalid, bready;
    logic        arvalid, arready, rvalid, rready;
    logic [11:0] awaddr, araddr;
    logic [31:0] wdata, rdata, got;
    logic [3:0]  wstrb;
    logic [1:0]  bresp, rresp, rsp;
    pad_ctrl_t   pad_ctrl;
    int          fails, checked, cyc;
    int          stall;                          // edges the master waits before ready
    logic [11:0] ofs [9];
    logic [31:0] rst_val [9];

    pad_hysteresis_drive_regs DUT (
        .mclk(mclk), .reset(reset), .awvalid(awvalid), .awready(awready),
        .awaddr(awaddr), .awprot(3'h0), .wvalid(wvalid), .wready(wready),
        .wdata(wdata), .wstrb(wstrb), .bvalid(bvalid), .bready(bready), .bresp(bresp),
        .arvalid(arvalid), .arready(arready), .araddr(araddr), .arprot(3'h0),
        .rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp),
        .pad_ctrl(pad_ctrl));

    // 25 MHz clock
    always #20 mclk = ~mclk;

    // ======================================================================
    // checking and closing
    // ======================================================================
    task automatic chk(input string n, input logic [31:0] g, input logic [31:0] e);
        checked++;
        if (g !== e) begin
            fails++;
            $display("BAD %s expected %h seen %h", n, e, g);
        end
    endtask

    task automatic report_and_stop;
        if (fails == 0 && checked > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    // hang guard: whole run needs well under a thousand cycles
    always @(posedge mclk) begin
        cyc++;
        if (cyc == 3000) begin
            fails++;
            report_and_stop();
        end
    end

    // ======================================================================
    // bus tasks; each ends one edge after release so strobes never clash
    // ======================================================================
    task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s,
                      output logic [1:0] r);
        logic aw_done, w_done;
        aw_done = 1'h0;
        w_done = 1'h0;
        awaddr <= a;
        wdata <= d;
        wstrb <= s;
        awvalid <= 1'h1;
        wvalid <= 1'h1;
        bready <= (stall == 0);
        while (!(aw_done && w_done)) begin
            @(posedge mclk);
            if (awvalid && awready) begin
                aw_done = 1'h1;
                awvalid <= 1'h0;
            end
            if (wvalid && wready) begin
                w_done = 1'h1;
                wvalid <= 1'h0;
            end
        end
        // an optional stall leaves the response waiting for bready
        repeat (stall) @(posedge mclk);
        bready <= 1'h1;
        do @(posedge mclk); while (bvalid !== 1'h1);
        r = bresp;
        bready <= 1'h0;
        @(posedge mclk);
    endtask

    task automatic rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
        araddr <= a;
        arvalid <= 1'h1;
        rready <= (stall == 0);
        do @(posedge mclk); while (arready !== 1'h1);
        arvalid <= 1'h0;
        repeat (stall) @(posedge mclk);
        rready <= 1'h1;
        do @(posedge mclk); while (rvalid !== 1'h1);
        d = rdata;
        r = rresp;
        rready <= 1'h0;
        @(posedge mclk);
    endtask

    // ======================================================================
    // main sequence
    // ======================================================================
    initial begin
        mclk = 1'h0;
        reset = 1'h1;
        {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
        {awaddr, araddr, wdata, wstrb} = '0;
        ofs = '{`OFS_P3A_HYST, `OFS_P3B_HYST, `OFS_P3C_HYST, `OFS_P3D_HYST,
                `OFS_P1A_DRIVE, `OFS_P1B_DRIVE, `OFS_P1C_DRIVE, `OFS_P1D_DRIVE,
                `OFS_P2A_DRIVE};
        rst_val = '{32'h0000_0000, 32'h0000_0000, 32'h0000_0000, 32'h0000_0000,
                    32'h0000_aaaa, 32'h0000_aaaa, 32'h0000_aa55, 32'h0000_aaaa,
                    32'h0000_5555};
        repeat (4) @(posedge mclk);
        reset <= 1'h0;
        @(posedge mclk);
        // reset values of every register
        for (int i = 0; i < 9; i++) begin
            rd(ofs[i], got, rsp);
            chk("reset value", got, rst_val[i]);
        end
        // masked writes on group C drive
        wr(`OFS_P1C_DRIVE, 32'h0000_ffff, 4'hf, rsp);
        rd(`OFS_P1C_DRIVE, got, rsp);
        chk("no mask write", got, 32'h0000_aa55);
        wr(`OFS_P1C_DRIVE, 32'h8000_0000, 4'hf, rsp);
        rd(`OFS_P1C_DRIVE, got, rsp);
        chk("top lane write", got, 32'h0000_2a55);
        wr(`OFS_P1C_DRIVE, 32'h0002_0002, 4'hf, rsp);
        rd(`OFS_P1C_DRIVE, got, rsp);
        chk("single lane write", got, 32'h0000_2a57);
        chk("pin0 pad code", 32'(pad_ctrl.drive_sel[2][0]), 32'(DRIVE_12MA));
        // every drive code on pin 7 of group A
        for (int c = 0; c < 4; c++) begin
            wr(`OFS_P1A_DRIVE, {2'h3, 14'h0000, 2'(c), 14'h0000}, 4'hf, rsp);
            chk("pin7 pad code", 32'(pad_ctrl.drive_sel[0][7]), 32'(c));
        end
        // from here on the master keeps both read and write answers waiting two edges
        stall = 2;
        // reserved and mask bits of a hysteresis register
        wr(`OFS_P3B_HYST, 32'hffff_ffff, 4'hf, rsp);
        chk("reserved write resp", 32'(rsp), 32'(RESP_OKAY));
        rd(`OFS_P3B_HYST, got, rsp);
        chk("hysteresis read", got, 32'h0000_00ff);
        chk("hysteresis pads", 32'(pad_ctrl.hysteresis_en[1]), 32'h0000_00ff);
        // the two low address bits select nothing
        rd(`OFS_P3B_HYST | 12'h003, got, rsp);
        chk("unaligned read", got, 32'h0000_00ff);
        // strobes gate data and mask lanes
        wr(`OFS_P3A_HYST, 32'hffff_ffff, 4'h5, rsp);
        chk("strobed set", 32'(pad_ctrl.hysteresis_en[0]), 32'h0000_00ff);
        wr(`OFS_P3A_HYST, 32'hffff_0000, 4'h3, rsp);
        chk("mask lanes off", 32'(pad_ctrl.hysteresis_en[0]), 32'h0000_00ff);
        // unmapped word on both channels
        wr(12'h104, 32'hffff_ffff, 4'hf, rsp);
        chk("unmapped write resp", 32'(rsp), 32'(RESP_DECERR));
        rd(12'h104, got, rsp);
        chk("unmapped read data", got, 32'h0000_0000);
        chk("unmapped read resp", 32'(rsp), 32'(RESP_DECERR));
        // mid-run reset brings every written setting back to its default
        reset <= 1'h1;
        repeat (4) @(posedge mclk);
        reset <= 1'h0;
        @(posedge mclk);
        chk("reset hysteresis pads", 32'(pad_ctrl.hysteresis_en[1]), 32'h0000_0000);
        chk("reset drive pads", 32'(pad_ctrl.drive_sel[0]), 32'h0000_aaaa);
        rd(`OFS_P1C_DRIVE, got, rsp);
        chk("reset drive read", got, 32'h0000_aa55);
        report_and_stop();
    end
endmodule // tb_pad_hysteresis_drive_regs
